// ### verilog/hai_pkg.sv
`default_nettype none
package hai_pkg;
	localparam int NCH    = 8;
	localparam int AW     = 5;
	localparam int DW     = 8;
	localparam int NSRC   = 3;
	localparam int SYNC_W = 23;

	// primary bank map
	localparam logic [AW-1:0] A_ID      = 5'h00;
	localparam logic [AW-1:0] A_LOS_ST  = 5'h04;
	localparam logic [AW-1:0] A_SC_ST   = 5'h05;
	localparam logic [AW-1:0] A_LOS_MSK = 5'h06;
	localparam logic [AW-1:0] A_SC_MSK  = 5'h07;
	localparam logic [AW-1:0] A_LOS_FLG = 5'h08;
	localparam logic [AW-1:0] A_SC_FLG  = 5'h09;
	localparam logic [AW-1:0] A_AIS_ST  = 5'h13;
	localparam logic [AW-1:0] A_AIS_MSK = 5'h14;
	localparam logic [AW-1:0] A_AIS_FLG = 5'h15;
	localparam logic [AW-1:0] A_BANK    = 5'h1f;

	// per source: loss of signal, short circuit, alarm indication
	localparam logic [AW-1:0] ST_ADDR  [NSRC] = '{A_LOS_ST, A_SC_ST, A_AIS_ST};
	localparam logic [AW-1:0] MSK_ADDR [NSRC] = '{A_LOS_MSK, A_SC_MSK, A_AIS_MSK};
	localparam logic [AW-1:0] FLG_ADDR [NSRC] = '{A_LOS_FLG, A_SC_FLG, A_AIS_FLG};

	localparam logic [DW-1:0] BANK_EXP_KEY = 8'haa;
	localparam logic [DW-1:0] BANK_RST     = 8'h00;
	localparam logic [DW-1:0] MASK_RST     = 8'h00;
	localparam logic [DW-1:0] FLAG_RST     = 8'h00;
	localparam logic [DW-1:0] DATA_ZERO    = 8'h00;
	// arbitrary identification value
	localparam logic [DW-1:0] ID_VALUE     = 8'h5a;

	// serial frame
	localparam int            SER_RW_BIT    = 0;
	localparam int            SER_ADDR_LSB  = 1;
	localparam logic [4:0]    SER_CNT_ZERO  = 5'h00;
	localparam logic [4:0]    SER_CNT_ONE   = 5'h01;
	localparam logic [4:0]    SER_CMD_LAST  = 5'h07;
	localparam logic [4:0]    SER_CMD_BITS  = 5'h08;
	localparam logic [4:0]    SER_LAST      = 5'h0f;
	localparam logic [4:0]    SER_FRAME     = 5'h10;

	typedef enum logic [0:0] {P_IDLE, P_DONE} hai_pstate_t;
endpackage
`default_nettype wire

// ### verilog/hai_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hai_reg_if;
	logic       req;
	logic       wr;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport initiator (output req, output wr, output addr, output wdata, input rdata);
	modport target    (input req, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### verilog/hai_serial.sv
`timescale 1ns/1ps
`default_nettype none
module hai_serial (
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// filtered serial pins
	input  wire logic      en,
	input  wire logic      sclk,
	input  wire logic      cs_n,
	input  wire logic      serial_in,
	output var  logic      serial_out,
	output var  logic      sdo_oe_n,
	// register access
	hai_reg_if.initiator   ri
);
	import hai_pkg::*;

	logic          sclk_d;
	logic [4:0]    cnt_reg;
	logic [DW-1:0] cmd_reg;
	logic [DW-1:0] din_reg;
	logic [DW-1:0] dout_reg;
	logic          rd_pend_reg;
	logic          active;
	logic          rise;
	logic          fall;
	logic          wr_go;
	logic          rd_go;

	assign active = en & ~cs_n;
	assign rise   = sclk & ~sclk_d;
	assign fall   = ~sclk & sclk_d;
	// write is issued on the sixteenth input edge
	assign wr_go  = active & rise & (cnt_reg == SER_LAST) & ~cmd_reg[SER_RW_BIT];
	assign rd_go  = rd_pend_reg & cmd_reg[SER_RW_BIT];

	assign ri.req   = wr_go | rd_go;
	assign ri.wr    = wr_go;
	// upper two command bits are simply never looked at
	assign ri.addr  = cmd_reg[SER_ADDR_LSB +: AW];
	assign ri.wdata = {serial_in, din_reg[DW-1:1]};

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk;
		end
	end

	// inputs sampled on rising serial clock, lsb first
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= SER_CNT_ZERO;
			cmd_reg <= DATA_ZERO;
			din_reg <= DATA_ZERO;
		end else if (!active) begin
			cnt_reg <= SER_CNT_ZERO;
		end else if (rise && cnt_reg != SER_FRAME) begin
			cnt_reg <= cnt_reg + SER_CNT_ONE;
			if (cnt_reg < SER_CMD_BITS) begin
				cmd_reg <= {serial_in, cmd_reg[DW-1:1]};
			end else begin
				din_reg <= {serial_in, din_reg[DW-1:1]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= active & rise & (cnt_reg == SER_CMD_LAST);
		end
	end

	// outputs change on falling serial clock during the data byte
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_reg <= DATA_ZERO;
			serial_out      <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (!active) begin
			sdo_oe_n <= 1'b1;
		end else if (rd_go) begin
			dout_reg <= ri.rdata;
		end else if (fall && cmd_reg[SER_RW_BIT] && cnt_reg >= SER_CMD_BITS
				&& cnt_reg != SER_FRAME) begin
			serial_out      <= dout_reg[0];
			dout_reg <= {1'b0, dout_reg[DW-1:1]};
			sdo_oe_n <= 1'b0;
		end
	end

	ser_count_a: assert property (@(posedge clk) disable iff (rst)
		cnt_reg <= SER_FRAME) else $error("serial bit count overran frame");
	ser_write_a: assert property (@(posedge clk) disable iff (rst)
		ri.req && ri.wr |-> cnt_reg == SER_LAST && !cmd_reg[SER_RW_BIT])
		else $error("serial write outside sixteenth bit");
	ser_read_a: assert property (@(posedge clk) disable iff (rst)
		rd_go |=> dout_reg == $past(ri.rdata))
		else $error("serial read data not captured");
	ser_wr_c: cover property (@(posedge clk) disable iff (rst) wr_go);
	ser_rd_c: cover property (@(posedge clk) disable iff (rst) rd_go ##[1:200] !sdo_oe_n);
endmodule
`default_nettype wire

// ### verilog/hai_top.sv
`timescale 1ns/1ps
`default_nettype none
module hai_top (
	// clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  RST,
	// mode straps
	input  wire logic                  HOST_SEL_SERIAL,
	input  wire logic                  BUS_MUX_SELECT,
	input  wire logic                  STROBE_STYLE_SELECT,
	// parallel port
	input  wire logic                  CS_N,
	input  wire logic                  STROBE_WR_N,
	input  wire logic                  RWSEL_RD_N,
	input  wire logic                  ADDR_LATCH,
	input  wire logic [hai_pkg::AW-1:0] ADDR,
	input  wire logic [hai_pkg::DW-1:0] DATA_IN,
	output var  logic [hai_pkg::DW-1:0] DATA_OUT,
	output var  logic                  DATA_OE_N,
	output var  logic                  HANDSHAKE_N,
	// serial port
	input  wire logic                  SER_CLK,
	input  wire logic                  SER_CS_N,
	input  wire logic                  SER_IN,
	output wire logic                  SER_OUT,
	output wire logic                  SER_OUT_OE_N,
	// alarm conditions from the line channels
	input  wire logic [hai_pkg::NCH-1:0] SIGNAL_ABSENT_IN,
	input  wire logic [hai_pkg::NCH-1:0] SHORT_CIRCUIT_IN,
	input  wire logic [hai_pkg::NCH-1:0] ALARM_IND_IN,
	// open-drain interrupt
	output wire logic                  INT_OUT,
	output var  logic                  INT_OE_N
);
	import hai_pkg::*;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// pin synchronisers
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] s1_reg;
	logic [SYNC_W-1:0] s2_reg;
	logic [SYNC_W-1:0] s3_reg;
	logic [SYNC_W-1:0] filt_reg;

	logic          cs_n_f;
	logic          strobe_f;
	logic          rwsel_f;
	logic          ale_f;
	logic [AW-1:0] addr_f;
	logic [DW-1:0] data_f;
	logic          sclk_f;
	logic          scs_n_f;
	logic          sdi_f;
	logic          sel_ser_f;
	logic          mux_f;
	logic          style_f;

	assign pin_raw = {CS_N, STROBE_WR_N, RWSEL_RD_N, ADDR_LATCH, ADDR, DATA_IN,
		SER_CLK, SER_CS_N, SER_IN, HOST_SEL_SERIAL, BUS_MUX_SELECT, STROBE_STYLE_SELECT};

	assign {cs_n_f, strobe_f, rwsel_f, ale_f, addr_f, data_f,
		sclk_f, scs_n_f, sdi_f, sel_ser_f, mux_f, style_f} = filt_reg;

	// a change is accepted only when stages two and three agree
	genvar gb;
	generate
		for (gb = 0; gb < SYNC_W; gb++) begin : g_sync
			always_ff @(posedge CLK_SYS) begin
				s1_reg[gb] <= pin_raw[gb];
				s2_reg[gb] <= s1_reg[gb];
				s3_reg[gb] <= s2_reg[gb];
				if (s2_reg[gb] == s3_reg[gb]) begin
					filt_reg[gb] <= s3_reg[gb];
				end
			end
		end
	endgenerate

	// straps are taken while reset is held and frozen afterwards
	logic serial_mode_reg;
	logic mux_mode_reg;
	logic rdwr_style_reg;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			serial_mode_reg <= sel_ser_f;
			mux_mode_reg    <= mux_f;
			rdwr_style_reg  <= style_f;
		end
	end

	// shared register access path
	hai_reg_if ri ();

	logic          acc_req;
	logic          acc_wr;
	logic [AW-1:0] acc_addr;
	logic [DW-1:0] acc_wdata;
	logic [DW-1:0] rd_data;
	logic [DW-1:0] bank_reg;
	logic          prim;

	// parallel side
	hai_pstate_t   pstate_reg;
	logic [AW-1:0] addr_lat_reg;
	logic          ale_d;
	logic          par_rd;
	logic          par_wr;
	logic          par_go;
	logic          par_end;
	logic [AW-1:0] par_addr;

	// strobe style: data strobe plus rw select, or separate rd/wr strobes
	always_comb begin
		if (rdwr_style_reg) begin
			par_rd = ~rwsel_f;
			par_wr = ~strobe_f & rwsel_f;
		end else begin
			par_rd = ~strobe_f & rwsel_f;
			par_wr = ~strobe_f & ~rwsel_f;
		end
	end

	assign par_go   = ~serial_mode_reg & ~cs_n_f & (par_rd | par_wr)
		& (pstate_reg == P_IDLE);
	assign par_end  = cs_n_f | ~(par_rd | par_wr);
	assign par_addr = mux_mode_reg ? addr_lat_reg : addr_f;

	// multiplexed bus: address is caught as the latch strobe falls
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ale_d        <= 1'b0;
			addr_lat_reg <= A_ID;
		end else begin
			ale_d <= ale_f;
			if (ale_d && !ale_f) begin
				addr_lat_reg <= data_f[AW-1:0];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pstate_reg <= P_IDLE;
		end else begin
			case (pstate_reg)
				P_IDLE: begin
					if (par_go) begin
						pstate_reg <= P_DONE;
					end
				end
				P_DONE: begin
					if (par_end) begin
						pstate_reg <= P_IDLE;
					end
				end
				default: pstate_reg <= P_IDLE;
			endcase
		end
	end

	// handshake stays asserted until the host drops its strobe
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			DATA_OUT    <= DATA_ZERO;
			DATA_OE_N   <= 1'b1;
			HANDSHAKE_N <= 1'b1;
		end else if (par_go) begin
			HANDSHAKE_N <= 1'b0;
			if (par_rd) begin
				DATA_OUT  <= rd_data;
				DATA_OE_N <= 1'b0;
			end
		end else if (pstate_reg == P_DONE && par_end) begin
			HANDSHAKE_N <= 1'b1;
			DATA_OE_N   <= 1'b1;
		end
	end

	// only one port is live, chosen by the strap
	always_comb begin
		if (serial_mode_reg) begin
			acc_req   = ri.req;
			acc_wr    = ri.wr;
			acc_addr  = ri.addr;
			acc_wdata = ri.wdata;
		end else begin
			acc_req   = par_go;
			acc_wr    = par_wr & ~par_rd;
			acc_addr  = par_addr;
			acc_wdata = data_f;
		end
	end

	assign ri.rdata = rd_data;

	hai_serial u_serial (
		.clk      (CLK_SYS),
		.rst      (RST),
		.en       (serial_mode_reg),
		.sclk     (sclk_f),
		.cs_n     (scs_n_f),
		.serial_in      (sdi_f),
		.serial_out      (SER_OUT),
		.sdo_oe_n (SER_OUT_OE_N),
		.ri       (ri.initiator)
	);

	// bank pointer; expanded registers are not part of this block and read zero
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			bank_reg <= BANK_RST;
		end else if (acc_req && acc_wr && acc_addr == A_BANK) begin
			bank_reg <= acc_wdata;
		end
	end

	assign prim = (bank_reg != BANK_EXP_KEY);

	// interrupt sources
	logic [NCH-1:0] src_in   [NSRC];
	logic [NCH-1:0] st_reg   [NSRC];
	logic [NCH-1:0] mask_reg [NSRC];
	logic [NCH-1:0] flag_reg [NSRC];
	logic [NCH-1:0] set_v    [NSRC];
	logic [NSRC-1:0] clr_v;
	logic [NSRC-1:0] pend_v;

	assign src_in[0] = SIGNAL_ABSENT_IN;
	assign src_in[1] = SHORT_CIRCUIT_IN;
	assign src_in[2] = ALARM_IND_IN;

	genvar gs;
	generate
		for (gs = 0; gs < NSRC; gs++) begin : g_src
			// edge of the live condition against the last status seen
			assign set_v[gs] = mask_reg[gs] & (src_in[gs] ^ st_reg[gs]);
			assign clr_v[gs] = acc_req & ~acc_wr & prim & (acc_addr == ST_ADDR[gs]);
			assign pend_v[gs] = |(flag_reg[gs] & mask_reg[gs]);

			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					st_reg[gs] <= src_in[gs];
				end else begin
					st_reg[gs] <= src_in[gs];
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					mask_reg[gs] <= MASK_RST;
				end else if (acc_req && acc_wr && prim && acc_addr == MSK_ADDR[gs]) begin
					mask_reg[gs] <= acc_wdata;
				end
			end

			// a new edge in the clearing cycle survives the clear
			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					flag_reg[gs] <= FLAG_RST;
				end else if (clr_v[gs]) begin
					flag_reg[gs] <= set_v[gs];
				end else begin
					flag_reg[gs] <= flag_reg[gs] | set_v[gs];
				end
			end

			masked_edge_a: assert property (
				1 |=> (flag_reg[gs] & ~$past(flag_reg[gs]) & ~$past(mask_reg[gs])) == DATA_ZERO)
				else $error("masked transition set a flag");
			edge_sets_a: assert property (
				|set_v[gs] |=> (flag_reg[gs] & $past(set_v[gs])) == $past(set_v[gs]))
				else $error("enabled transition did not set flag");
			edge_int_a: assert property (
				|set_v[gs] |=> ##1 !INT_OE_N) else $error("interrupt not driven after edge");
			read_clear_a: assert property (
				clr_v[gs] && set_v[gs] == DATA_ZERO |=> flag_reg[gs] == FLAG_RST)
				else $error("status read did not clear flags");
			status_follow_a: assert property (
				##1 st_reg[gs] == $past(src_in[gs])) else $error("status bit not following");
		end
	endgenerate

	// read mux; reserved and unmapped addresses read zero
	always_comb begin
		rd_data = DATA_ZERO;
		if (acc_addr == A_BANK) begin
			rd_data = bank_reg;
		end else if (prim) begin
			if (acc_addr == A_ID) begin
				rd_data = ID_VALUE;
			end
			for (int s = 0; s < NSRC; s++) begin
				if (acc_addr == ST_ADDR[s]) begin
					rd_data = st_reg[s];
				end
				if (acc_addr == MSK_ADDR[s]) begin
					rd_data = mask_reg[s];
				end
				if (acc_addr == FLG_ADDR[s]) begin
					rd_data = flag_reg[s];
				end
			end
		end
	end

	// open-drain: pin is pulled low only, release relies on the board pull-up
	assign INT_OUT = 1'b0;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			INT_OE_N <= 1'b1;
		end else begin
			INT_OE_N <= ~(|pend_v);
		end
	end

	int_release_a: assert property (
		$rose(INT_OE_N) |-> $past(pend_v) == '0) else $error("interrupt released while pending");
	int_hold_a: assert property (
		|pend_v |=> !INT_OE_N) else $error("interrupt not held while pending");
	bank_key_a: assert property (
		acc_req && acc_wr && acc_addr == A_BANK && acc_wdata == BANK_EXP_KEY |=> !prim)
		else $error("bank key did not select expanded bank");
	par_read_a: assert property (
		par_go && par_rd |=> !HANDSHAKE_N && !DATA_OE_N && DATA_OUT == $past(rd_data))
		else $error("parallel read not answered");
	par_release_a: assert property (
		pstate_reg == P_DONE && par_end |=> HANDSHAKE_N && DATA_OE_N)
		else $error("parallel handshake not released");

	par_wr_c: cover property (par_go && par_wr ##[1:50] HANDSHAKE_N);
	int_c: cover property ($fell(INT_OE_N) ##[1:500] $rose(INT_OE_N));
	bank_c: cover property (!prim ##[1:500] prim);
endmodule
`default_nettype wire

// ### verif/hai_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hai_host_model (
	// clock and straps
	input  wire logic                   clk,
	input  wire logic                   serial_mode,
	input  wire logic                   mux_mode,
	input  wire logic                   rdwr_style,
	// parallel side
	output var  logic                   cs_n,
	output var  logic                   strobe_wr_n,
	output var  logic                   rwsel_rd_n,
	output var  logic                   addr_latch,
	output var  logic [hai_pkg::AW-1:0] addr,
	output var  logic [hai_pkg::DW-1:0] data,
	input  wire logic [hai_pkg::DW-1:0] data_out,
	input  wire logic                   data_oe_n,
	input  wire logic                   handshake_n,
	// serial side
	output var  logic                   ser_clk,
	output var  logic                   ser_cs_n,
	output var  logic                   ser_in,
	input  wire logic                   ser_out
);
	import hai_pkg::*;

	// bus enable seen together with the last parallel answer
	logic oe_seen;

	initial begin
		{cs_n, strobe_wr_n, rwsel_rd_n, ser_cs_n} = 4'hf;
		{addr_latch, ser_clk, ser_in} = 3'h0;
		addr = 5'h00;
		data = 8'h00;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic wait_hs(input logic lvl, output logic ok);
		int i;
		ok = 1'b0;
		// look just after the edge, once the registered handshake has settled
		for (i = 0; i < 40 && !ok; i++) begin
			@(posedge clk);
			#2;
			ok = (handshake_n === lvl);
		end
	endtask

	// one register access in whichever port the straps picked
	task automatic access(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] wd,
			output logic [DW-1:0] rdv, output logic ok);
		int          i;
		logic [15:0] frame;
		rdv = 8'h00;
		ok = 1'b1;
		if (serial_mode) begin
			// top command bits set on purpose, the port must ignore them
			frame = {wd, 2'b11, a, rd};
			ser_cs_n = 1'b0;
			for (i = 0; i < 16; i++) begin
				ser_in = frame[i];
				step(5);
				if (i >= 8)
					rdv[i-8] = ser_out;
				ser_clk = 1'b1;
				step(5);
				ser_clk = 1'b0;
			end
			step(5);
			ser_cs_n = 1'b1;
			// released line must not keep the last bit
			ser_in = ~ser_in;
			step(5);
		end else begin
			if (mux_mode) begin
				data = {3'b111, a};
				addr_latch = 1'b1;
				step(6);
				addr_latch = 1'b0;
				step(6);
				addr = ~a;
			end else begin
				addr = a;
			end
			data = rd ? ~data : wd;
			cs_n = 1'b0;
			if (rdwr_style) begin
				strobe_wr_n = rd;
				rwsel_rd_n = !rd;
			end else begin
				strobe_wr_n = 1'b0;
				rwsel_rd_n = rd;
			end
			wait_hs(1'b0, ok);
			rdv = data_out;
			oe_seen = data_oe_n;
			{cs_n, strobe_wr_n, rwsel_rd_n} = 3'h7;
			data = ~data;
			addr = ~addr;
			if (ok)
				wait_hs(1'b1, ok);
			step(3);
		end
	endtask
endmodule
`default_nettype wire

// ### verif/hai_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hai_top_tb_top;
	import hai_pkg::*;

	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            sel_ser = 1'b0, mux = 1'b0, style = 1'b0;
	logic            cs_n, swr_n, rwr_n, ale, sclk, scs_n, sin;
	logic [AW-1:0]   addr;
	logic [DW-1:0]   din, dout;
	logic            doe_n, hs_n, sout, soe_n, int_out, int_oe_n;
	logic [NCH-1:0]  cond [NSRC] = '{8'h00, 8'h00, 8'h00};
	int              err_count = 0;
	int              checked = 0;
	int              c, s;
	logic [DW-1:0]   v;
	// pull-up on the shared interrupt line
	wire             int_line = int_oe_n ? 1'b1 : int_out;

	always #12.5 clk = ~clk;

	hai_top i_hai_top (.CLK_SYS(clk), .RST(rst), .HOST_SEL_SERIAL(sel_ser),
		.BUS_MUX_SELECT(mux), .STROBE_STYLE_SELECT(style), .CS_N(cs_n),
		.STROBE_WR_N(swr_n), .RWSEL_RD_N(rwr_n), .ADDR_LATCH(ale), .ADDR(addr),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n), .HANDSHAKE_N(hs_n),
		.SER_CLK(sclk), .SER_CS_N(scs_n), .SER_IN(sin), .SER_OUT(sout),
		.SER_OUT_OE_N(soe_n), .SIGNAL_ABSENT_IN(cond[0]), .SHORT_CIRCUIT_IN(cond[1]),
		.ALARM_IND_IN(cond[2]), .INT_OUT(int_out), .INT_OE_N(int_oe_n));

	hai_host_model i_hai_host_model (.clk(clk), .serial_mode(sel_ser), .mux_mode(mux),
		.rdwr_style(style), .cs_n(cs_n), .strobe_wr_n(swr_n), .rwsel_rd_n(rwr_n),
		.addr_latch(ale), .addr(addr), .data(din), .data_out(dout), .handshake_n(hs_n),
		.data_oe_n(doe_n), .ser_clk(sclk), .ser_cs_n(scs_n), .ser_in(sin), .ser_out(sout));

	task automatic results();
		$display("checks=%0d mismatches=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] wd);
		logic ok;
		i_hai_host_model.access(rd, a, wd, v, ok);
		if (!ok) begin
			err_count++;
			results();
		end
	endtask

	task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		xfer(1'b1, a, DATA_ZERO);
		check(v, exp);
	endtask

	task automatic wrd(input logic [AW-1:0] a, input logic [DW-1:0] d);
		xfer(1'b0, a, d);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk_int(input logic exp);
		check({7'h00, int_line}, {7'h00, exp});
	endtask

	initial begin
		// reset longer than four cycles: strap filters need it
		for (c = 0; c < 5; c++) begin
			rst = 1'b1;
			sel_ser = (c == 4);
			mux = c[1];
			style = c[0];
			tick(6);
			rst = 1'b0;
			tick(6);
			rdc(A_ID, ID_VALUE);
			if (c < 4)
				check({7'h00, i_hai_host_model.oe_seen}, 8'h00);
			rdc(A_SC_MSK, MASK_RST);
			wrd(A_SC_MSK, 8'h3c ^ 8'(c));
			rdc(A_SC_MSK, 8'h3c ^ 8'(c));
			rdc(5'h10, DATA_ZERO);
			check({7'h00, doe_n}, 8'h01);
			$display("access test in mode %0d done", c);
		end
		for (s = 0; s < NSRC; s++) begin
			cond[s] = 8'h81;
			tick(3);
			rdc(FLG_ADDR[s], FLAG_RST);
			chk_int(1'b1);
			rdc(ST_ADDR[s], 8'h81);
			wrd(MSK_ADDR[s], 8'h01);
			cond[s] = 8'h82;
			tick(3);
			chk_int(1'b0);
			rdc(FLG_ADDR[s], 8'h01);
			rdc(FLG_ADDR[s], 8'h01);
			wrd(FLG_ADDR[s], 8'h00);
			rdc(FLG_ADDR[s], 8'h01);
			rdc(ST_ADDR[s], 8'h82);
			rdc(FLG_ADDR[s], FLAG_RST);
			chk_int(1'b1);
			cond[s] = 8'h00;
			tick(3);
			rdc(ST_ADDR[s], 8'h00);
			$display("interrupt test for source %0d done", s);
		end
		cond[0] = 8'h01;
		cond[2] = 8'h01;
		tick(3);
		chk_int(1'b0);
		rdc(ST_ADDR[0], 8'h01);
		chk_int(1'b0);
		rdc(ST_ADDR[2], 8'h01);
		chk_int(1'b1);
		$display("shared interrupt test done");
		wrd(A_BANK, BANK_EXP_KEY);
		rdc(A_BANK, BANK_EXP_KEY);
		rdc(A_LOS_MSK, DATA_ZERO);
		wrd(A_LOS_MSK, 8'hff);
		wrd(A_BANK, BANK_RST);
		rdc(A_LOS_MSK, 8'h01);
		check({7'h00, soe_n}, 8'h01);
		$display("bank test done");
		results();
	end
endmodule
`default_nettype wire
